// file: logic/wt_pkg.sv
// Constants and types shared by the wide timer and its prescaler.
package wt_pkg;

	// ---------------------------------------------------------------
	// Register offsets on the internal byte bus
	// ---------------------------------------------------------------
	localparam logic [3:0] ADDR_GTC    = 4'h0;
	localparam logic [3:0] ADDR_CTRL_A = 4'h1;
	localparam logic [3:0] ADDR_CTRL_B = 4'h2;
	localparam logic [3:0] ADDR_CNT_L  = 4'h3;
	localparam logic [3:0] ADDR_CNT_H  = 4'h4;
	localparam logic [3:0] ADDR_CMPA_L = 4'h5;
	localparam logic [3:0] ADDR_CMPA_H = 4'h6;
	localparam logic [3:0] ADDR_CMPB_L = 4'h7;
	localparam logic [3:0] ADDR_CMPB_H = 4'h8;
	localparam logic [3:0] ADDR_CAP_L  = 4'h9;
	localparam logic [3:0] ADDR_CAP_H  = 4'ha;
	localparam logic [3:0] ADDR_FLAGS  = 4'hb;
	localparam logic [3:0] ADDR_MASK   = 4'hc;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int GTC_RESTART_BIT = 0;
	localparam int FLAG_OVF_BIT    = 7;
	localparam int FLAG_CMPA_BIT   = 6;
	localparam int FLAG_CMPB_BIT   = 5;
	localparam int FLAG_CAP_BIT    = 3;
	localparam logic [7:0] FLAG_USED = 8'he8;
	localparam int COMA_LSB        = 6;
	localparam int COMB_LSB        = 4;
	localparam int WGM_LO_LSB      = 0;
	localparam int NOISE_BIT       = 7;
	localparam int EDGE_BIT        = 6;
	localparam int WGM_HI_LSB      = 3;
	localparam int CS_LSB          = 0;

	// ---------------------------------------------------------------
	// Clock select codes
	// ---------------------------------------------------------------
	localparam logic [2:0] CS_STOP     = 3'h0;
	localparam logic [2:0] CS_DIV1     = 3'h1;
	localparam logic [2:0] CS_DIV8     = 3'h2;
	localparam logic [2:0] CS_DIV64    = 3'h3;
	localparam logic [2:0] CS_DIV256   = 3'h4;
	localparam logic [2:0] CS_DIV1024  = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;

	// ---------------------------------------------------------------
	// Counter values, reset values and timing counts
	// ---------------------------------------------------------------
	localparam logic [15:0] COUNT_FLOOR = 16'h0000;
	localparam logic [15:0] COUNT_MAX   = 16'hffff;
	localparam logic [15:0] TOP_8BIT    = 16'h00ff;
	localparam logic [15:0] TOP_9BIT    = 16'h01ff;
	localparam logic [15:0] TOP_10BIT   = 16'h03ff;
	localparam logic [7:0]  RST_BYTE    = 8'h00;
	localparam logic [15:0] RST_WORD    = 16'h0000;
	localparam logic [1:0]  NOISE_LAST  = 2'h3;
	localparam int unsigned PRE_TAP_BITS [4] = '{3, 6, 8, 10};

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wrData;
		logic       wrEn;
		logic       rdEn;
	} wt_io_req_t;

	typedef enum logic [1:0] {
		WT_DIR_UP   = 2'b01,
		WT_DIR_DOWN = 2'b10
	} wt_dir_t;

	typedef struct packed {
		logic            gtcRestart;
		logic [7:0]      ctrlA;
		logic [7:0]      ctrlB;
		logic [15:0]     count;
		logic [7:0]      hold;
		logic [1:0][15:0] cmpBuf;
		logic [1:0][15:0] cmpAct;
		logic [15:0]     capture;
		logic [7:0]      flags;
		logic [7:0]      mask;
		logic [7:0]      irq;
		wt_dir_t         dir;
		logic [2:0]      extSync;
		logic            extLevel;
		logic [2:0]      capSync;
		logic            capLevel;
		logic            capFilt;
		logic [1:0]      capCnt;
		logic [1:0]      cmpOut;
		logic            atFloor;
		logic            atMax;
		logic [7:0]      rdData;
	} wt_state_t;

	typedef struct packed {
		logic [9:0] count;
	} wt_pre_state_t;

endpackage : wt_pkg

// file: logic/wt_prescaler.sv
// Free-running shared prescaler with four tap enables and a restart input.
`timescale 1ns/1ps
module wt_prescaler
	import wt_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire logic       restart,
	output logic [3:0]      tapPulse
);

	wt_pre_state_t st_q;
	wt_pre_state_t st_d;

	// ---------------------------------------------------------------
	// Divider
	// ---------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		if (restart) begin
			st_d.count = 10'h000; // R2
		end else begin
			st_d.count = 10'(st_q.count + 10'h001);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Each tap fires once per full turn of its low counter bits.
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gTap
			assign tapPulse[g] = ~restart & (&st_q.count[PRE_TAP_BITS[g]-1:0]);
		end
	endgenerate

endmodule : wt_prescaler

// file: logic/wt_timer.sv
// Sixteen-bit timer with shared prescaler control and byte-wide CPU access.
//
// Contract
// (R1) Writing restart bit one resets the prescaler.
// (R2) Shared prescaler restarts both timers' phase together.
// (R3) Control bits seven to one read zero.
// (R4) Counter, compares, capture are sixteen-bit registers.
// (R5) Two control registers are plain byte registers.
// (R6) Each interrupt is a flag, individually masked.
// (R7) Tick from prescaler or pin; none stops.
// (R8) Compare match sets flag and drives pin.
// (R9) Compare A as top: no PWM, buffered.
// (R10) Capture copies counter on selected trigger edge.
// (R11) Floor at zero, maximum at all ones.
// (R12) Top is fixed, compare A or capture.
// (R13) One high-byte holding register shared by all.
// (R14) Low write loads holding byte plus low.
// (R15) Low read copies high byte into holder.
// (R16) Compare reads bypass the holding register.
// (R17) CPU writes high first, reads low first.
// (R18) Main code masks interrupts around byte pairs.
// (R19) CPU counter write beats count and clear.
// (R20) External pin ticks on chosen edge.
// (R21) Restart bit clears itself next clock.
`timescale 1ns/1ps
module wt_timer
	import wt_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire wt_io_req_t ioReq,
	input  wire logic       extCountPin,
	input  wire logic       capturePin,
	input  wire logic       comparatorOut,
	input  wire logic       captureFromComparator,
	output logic [7:0]      ioRdData,
	output logic            irqOverflow,
	output logic            irqCompareA,
	output logic            irqCompareB,
	output logic            irqCapture,
	output logic            cmpOutA,
	output logic            cmpOutB,
	output logic            countFloor,
	output logic            countMax
);

	wt_state_t   st_q;
	wt_state_t   st_d;
	logic [3:0]  tapPulse;
	logic        tick;
	logic        capTrig;
	logic        cntWrite;

	wt_prescaler uPre (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.restart  (st_q.gtcRestart),
		.tapPulse (tapPulse)
	);

	// Pin level for one compare channel; match and wrap are the events.
	function automatic logic pinNext(input logic [1:0] com, input logic match,
		input logic wrap, input logic up, input logic pwm, input logic dual,
		input logic cur);
		logic r;
		r = cur;
		if (!pwm) begin
			case (com)
				2'h1: if (match) r = ~cur;
				2'h2: if (match) r = 1'b0;
				2'h3: if (match) r = 1'b1;
				default: r = cur;
			endcase
		end else if (com[1]) begin
			if (match) begin
				r = (dual & ~up) ^ com[0];
			end else if (wrap && !dual) begin
				r = ~com[0];
			end
		end
		return r;
	endfunction : pinNext

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		logic [3:0]  wgm;
		logic [2:0]  cs;
		logic [15:0] top;
		logic        pwm;
		logic        dual;
		logic        topCmpA;
		logic        topCap;
		logic        wrap;
		logic        up;
		logic        trigSrc;
		logic [1:0]  match;
		logic [1:0]  com;
		logic [7:0]  setF;
		logic [7:0]  clrF;
		st_d    = st_q;
		wgm     = {st_q.ctrlB[WGM_HI_LSB +: 2], st_q.ctrlA[WGM_LO_LSB +: 2]};
		cs      = st_q.ctrlB[CS_LSB +: 3];
		pwm     = !(wgm == 4'h0 || wgm == 4'h4 || wgm == 4'hc);
		dual    = (wgm inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
		topCmpA = pwm && (wgm inside {4'h9, 4'hb, 4'hf});
		topCap  = (wgm inside {4'h8, 4'ha, 4'hc, 4'he});
		wrap    = 1'b0;
		setF    = 8'h00;
		clrF    = 8'h00;
		com     = 2'h0;
		up      = (st_q.dir == WT_DIR_UP);
		st_d.gtcRestart = 1'b0; // R21
		st_d.rdData     = RST_BYTE;

		case (wgm) // R12
			4'h1, 4'h5: top = TOP_8BIT;
			4'h2, 4'h6: top = TOP_9BIT;
			4'h3, 4'h7: top = TOP_10BIT;
			4'h4, 4'h9, 4'hb, 4'hf: top = st_q.cmpAct[0];
			4'h8, 4'ha, 4'hc, 4'he: top = st_q.capture;
			default: top = COUNT_MAX;
		endcase

		// External pin: a level counts once the last two samples agree.
		st_d.extSync = {st_q.extSync[1:0], extCountPin};
		if (st_q.extSync[1] == st_q.extSync[2]) begin
			st_d.extLevel = st_q.extSync[2];
		end

		case (cs) // R7
			CS_DIV1:     tick = 1'b1;
			CS_DIV8:     tick = tapPulse[0];
			CS_DIV64:    tick = tapPulse[1];
			CS_DIV256:   tick = tapPulse[2];
			CS_DIV1024:  tick = tapPulse[3];
			CS_EXT_FALL: tick = st_q.extLevel & ~st_d.extLevel; // R20
			CS_EXT_RISE: tick = ~st_q.extLevel & st_d.extLevel; // R20
			default:     tick = 1'b0;
		endcase

		// Counter unit.
		if (tick) begin
			if (dual) begin
				if (up) begin
					if (st_q.count >= top) begin
						st_d.dir   = WT_DIR_DOWN;
						st_d.count = 16'(st_q.count - 16'h0001);
					end else begin
						st_d.count = 16'(st_q.count + 16'h0001);
					end
				end else if (st_q.count == COUNT_FLOOR) begin
					st_d.dir           = WT_DIR_UP;
					st_d.count         = 16'(st_q.count + 16'h0001);
					setF[FLAG_OVF_BIT] = 1'b1;
				end else begin
					st_d.count = 16'(st_q.count - 16'h0001);
				end
			end else if (st_q.count == top) begin
				wrap               = 1'b1;
				st_d.count         = COUNT_FLOOR;
				st_d.dir           = WT_DIR_UP;
				setF[FLAG_OVF_BIT] = pwm || (st_q.count == COUNT_MAX);
			end else begin
				st_d.count = 16'(st_q.count + 16'h0001);
				st_d.dir   = WT_DIR_UP;
			end
		end

		// Compare units; PWM modes take the buffer at top only.
		for (int i = 0; i < 2; i++) begin
			match[i] = tick && (st_q.count == st_q.cmpAct[i]); // R8
			com      = (i == 0) ? st_q.ctrlA[COMA_LSB +: 2] : st_q.ctrlA[COMB_LSB +: 2];
			if (!pwm || (tick && st_q.count == top)) begin
				st_d.cmpAct[i] = st_q.cmpBuf[i]; // R9
			end
			if (!(i == 0 && topCmpA)) begin // R9
				st_d.cmpOut[i] = pinNext(com, match[i], wrap, up, pwm, dual,
					st_q.cmpOut[i]); // R8
			end
		end
		setF[FLAG_CMPA_BIT] = match[0]; // R8
		setF[FLAG_CMPB_BIT] = match[1]; // R8

		// Capture trigger with optional four-sample noise filter.
		st_d.capSync = {st_q.capSync[1:0], capturePin};
		if (st_q.capSync[1] == st_q.capSync[2]) begin
			st_d.capLevel = st_q.capSync[2];
		end
		trigSrc = captureFromComparator ? comparatorOut : st_q.capLevel;
		if (!st_q.ctrlB[NOISE_BIT] || trigSrc == st_q.capFilt) begin
			st_d.capCnt  = 2'h0;
			st_d.capFilt = trigSrc;
		end else if (st_q.capCnt == NOISE_LAST) begin
			st_d.capCnt  = 2'h0;
			st_d.capFilt = trigSrc;
		end else begin
			st_d.capCnt = 2'(st_q.capCnt + 2'h1);
		end
		capTrig = !topCap && (st_d.capFilt != st_q.capFilt)
			&& (st_d.capFilt == st_q.ctrlB[EDGE_BIT]);
		if (capTrig) begin
			st_d.capture       = st_q.count; // R10
			setF[FLAG_CAP_BIT] = 1'b1; // R10
		end

		// CPU reads; answer registered one cycle later.
		if (ioReq.rdEn) begin
			case (ioReq.addr)
				ADDR_GTC:    st_d.rdData = {7'h00, st_q.gtcRestart}; // R3
				ADDR_CTRL_A: st_d.rdData = st_q.ctrlA; // R5
				ADDR_CTRL_B: st_d.rdData = st_q.ctrlB; // R5
				ADDR_CNT_L: begin
					st_d.rdData = st_q.count[7:0];
					st_d.hold   = st_q.count[15:8]; // R15
				end
				ADDR_CNT_H:  st_d.rdData = st_q.hold; // R13
				ADDR_CMPA_L: st_d.rdData = st_q.cmpBuf[0][7:0]; // R16
				ADDR_CMPA_H: st_d.rdData = st_q.cmpBuf[0][15:8]; // R16
				ADDR_CMPB_L: st_d.rdData = st_q.cmpBuf[1][7:0]; // R16
				ADDR_CMPB_H: st_d.rdData = st_q.cmpBuf[1][15:8]; // R16
				ADDR_CAP_L: begin
					st_d.rdData = st_q.capture[7:0];
					st_d.hold   = st_q.capture[15:8]; // R15
				end
				ADDR_CAP_H:  st_d.rdData = st_q.hold; // R13
				ADDR_FLAGS:  st_d.rdData = st_q.flags;
				ADDR_MASK:   st_d.rdData = st_q.mask;
				default:     st_d.rdData = RST_BYTE;
			endcase
		end

		// CPU writes; these come last so they override counting.
		cntWrite = ioReq.wrEn && ioReq.addr == ADDR_CNT_L;
		if (ioReq.wrEn) begin
			case (ioReq.addr)
				ADDR_GTC:    st_d.gtcRestart = ioReq.wrData[GTC_RESTART_BIT]; // R1
				ADDR_CTRL_A: st_d.ctrlA = ioReq.wrData; // R5
				ADDR_CTRL_B: st_d.ctrlB = ioReq.wrData; // R5
				ADDR_CNT_H, ADDR_CMPA_H, ADDR_CMPB_H, ADDR_CAP_H: begin
					st_d.hold = ioReq.wrData; // R13
				end
				ADDR_CNT_L:  st_d.count = {st_q.hold, ioReq.wrData}; // R14 R19
				ADDR_CMPA_L: begin
					st_d.cmpBuf[0] = {st_q.hold, ioReq.wrData}; // R14 R4
					if (!pwm) begin
						st_d.cmpAct[0] = {st_q.hold, ioReq.wrData};
					end
				end
				ADDR_CMPB_L: begin
					st_d.cmpBuf[1] = {st_q.hold, ioReq.wrData}; // R14 R4
					if (!pwm) begin
						st_d.cmpAct[1] = {st_q.hold, ioReq.wrData};
					end
				end
				ADDR_CAP_L: begin
					if (topCap) begin
						st_d.capture = {st_q.hold, ioReq.wrData}; // R14 R4
					end
				end
				ADDR_FLAGS:  clrF = ioReq.wrData & FLAG_USED;
				ADDR_MASK:   st_d.mask = ioReq.wrData & FLAG_USED; // R6
				default:     st_d.mask = st_d.mask;
			endcase
		end

		// A flag set in the cycle of its clear stays set.
		st_d.flags   = (st_q.flags & ~clrF) | setF; // R6
		st_d.irq     = st_d.flags & st_d.mask; // R6
		st_d.atFloor = (st_d.count == COUNT_FLOOR); // R11
		st_d.atMax   = (st_d.count == COUNT_MAX); // R11
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			st_q     <= '0;
			st_q.dir <= WT_DIR_UP;
			st_q.atFloor <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign ioRdData    = st_q.rdData;
	assign irqOverflow = st_q.irq[FLAG_OVF_BIT];
	assign irqCompareA = st_q.irq[FLAG_CMPA_BIT];
	assign irqCompareB = st_q.irq[FLAG_CMPB_BIT];
	assign irqCapture  = st_q.irq[FLAG_CAP_BIT];
	assign cmpOutA     = st_q.cmpOut[0];
	assign cmpOutB     = st_q.cmpOut[1];
	assign countFloor  = st_q.atFloor;
	assign countMax    = st_q.atMax;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cbSys @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	logic gtcWrOne;
	assign gtcWrOne = ioReq.wrEn && ioReq.addr == ADDR_GTC && ioReq.wrData[GTC_RESTART_BIT];

	property p_restart_set;
		gtcWrOne |=> st_q.gtcRestart;
	endproperty
	a_restart_set: assert property (p_restart_set) else $error("restart bit not set"); // R1

	property p_restart_clear;
		st_q.gtcRestart && !gtcWrOne |=> !st_q.gtcRestart;
	endproperty
	a_restart_clear: assert property (p_restart_clear) else $error("restart stuck"); // R21

	property p_prescaler_phase;
		st_q.gtcRestart |=> (tapPulse == 4'h0) [*7];
	endproperty
	a_prescaler_phase: assert property (p_prescaler_phase) else $error("tap too soon"); // R2

	property p_reserved_zero;
		ioReq.rdEn && ioReq.addr == ADDR_GTC |=> ioRdData[7:1] == 7'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // R3

	property p_ctrl_write;
		ioReq.wrEn && ioReq.addr == ADDR_CTRL_B |=> st_q.ctrlB == $past(ioReq.wrData);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost"); // R5

	property p_low_write;
		cntWrite |=> st_q.count == {$past(st_q.hold), $past(ioReq.wrData)};
	endproperty
	a_low_write: assert property (p_low_write) else $error("counter write wrong"); // R14

	property p_low_read;
		ioReq.rdEn && ioReq.addr == ADDR_CNT_L
			|=> st_q.hold == $past(st_q.count[15:8]) && ioRdData == $past(st_q.count[7:0]);
	endproperty
	a_low_read: assert property (p_low_read) else $error("holding byte wrong"); // R15

	property p_cmp_direct;
		ioReq.rdEn && ioReq.addr == ADDR_CMPA_H |=> ioRdData == $past(st_q.cmpBuf[0][15:8]);
	endproperty
	a_cmp_direct: assert property (p_cmp_direct) else $error("compare read via holder"); // R16

	property p_stopped;
		st_q.ctrlB[CS_LSB +: 3] == CS_STOP && !cntWrite |=> $stable(st_q.count);
	endproperty
	a_stopped: assert property (p_stopped) else $error("counter moved while stopped"); // R7

	property p_cmp_flag;
		tick && st_q.count == st_q.cmpAct[0] |=> st_q.flags[FLAG_CMPA_BIT];
	endproperty
	a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag missing"); // R8

	property p_irq_mask;
		irqCapture == (st_q.flags[FLAG_CAP_BIT] && st_q.mask[FLAG_CAP_BIT]);
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("capture irq not masked"); // R6

	property p_capture;
		capTrig |=> st_q.capture == $past(st_q.count) && st_q.flags[FLAG_CAP_BIT];
	endproperty
	a_capture: assert property (p_capture) else $error("capture wrong"); // R10

	property p_floor;
		countFloor == (st_q.count == COUNT_FLOOR) && countMax == (st_q.count == COUNT_MAX);
	endproperty
	a_floor: assert property (p_floor) else $error("floor or max flag wrong"); // R11

	property p_ext_rise;
		st_q.ctrlB[CS_LSB +: 3] == CS_EXT_RISE && st_q.extSync[2:1] == 2'b11
			&& !st_q.extLevel && !cntWrite && st_q.ctrlA[1:0] == 2'h0
			&& st_q.ctrlB[4:3] == 2'h0 |=> st_q.count == 16'($past(st_q.count) + 16'h0001);
	endproperty
	a_ext_rise: assert property (p_ext_rise) else $error("rising edge not counted"); // R20

	c_overflow: cover property (st_q.flags[FLAG_OVF_BIT] && !$past(st_q.flags[FLAG_OVF_BIT]));
	c_capture: cover property (capTrig);
	c_ext_tick: cover property (tick && st_q.ctrlB[CS_LSB +: 3] == CS_EXT_FALL);
	c_restart: cover property (st_q.gtcRestart);

endmodule : wt_timer

// file: tb/wt_cpu_model.sv
// Byte bus master standing in for the CPU core, with single and paired accesses.
`timescale 1ns/1ps
module wt_cpu_model
	import wt_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic [7:0] ioRdData,
	output wt_io_req_t      ioReq
);

	initial begin
		ioReq = '0;
	end

	// ---------------------------------------------------------------
	// Single byte accesses
	// ---------------------------------------------------------------
	task automatic wr8(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		ioReq <= '{addr: a, wrData: d, wrEn: 1'b1, rdEn: 1'b0};
		@(posedge sys_clk);
		ioReq.wrEn <= 1'b0;
	endtask : wr8

	task automatic rd8(input logic [3:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		ioReq <= '{addr: a, wrData: ~ioReq.wrData, wrEn: 1'b0, rdEn: 1'b1};
		@(posedge sys_clk);
		ioReq.rdEn <= 1'b0;
		#1;
		d = ioRdData;
	endtask : rd8

	// ---------------------------------------------------------------
	// Word accesses
	// ---------------------------------------------------------------
	// The two halves go out with nothing in between, so no other access can disturb the holder.
	task automatic wr16(input logic [3:0] aLow, input logic [15:0] v);
		wr8(aLow + 4'h1, v[15:8]);
		wr8(aLow, v[7:0]);
	endtask : wr16

	task automatic rd16(input logic [3:0] aLow, output logic [15:0] v);
		rd8(aLow, v[7:0]);
		rd8(aLow + 4'h1, v[15:8]);
	endtask : rd16

endmodule : wt_cpu_model

// file: tb/test_wt_timer.sv
// Self-checking bench for the wide timer driven through its byte bus.
`timescale 1ns/1ps
module test_wt_timer;
	import wt_pkg::*;

	logic        sys_clk;
	logic        reset_n;
	wt_io_req_t  ioReq;
	logic [7:0]  rdData;
	logic        extPin;
	logic        capPin;
	logic        cmpOut;
	logic        capFromCmp;
	logic        irqOverflow;
	logic        irqCompareA;
	logic        irqCompareB;
	logic        irqCapture;
	logic        countFloor;
	logic        countMax;
	logic        cmpA;
	logic        cmpB;
	logic [7:0]  b;
	logic [15:0] w;
	int          errors;
	int          nTests;
	localparam logic [3:0] ZERO_REGS [6] = '{ADDR_GTC, ADDR_CTRL_A, ADDR_CTRL_B,
		ADDR_FLAGS, ADDR_MASK, 4'hd};

	wt_cpu_model cpu (.sys_clk(sys_clk), .ioRdData(rdData), .ioReq(ioReq));

	wt_timer dut (
		.sys_clk(sys_clk), .reset_n(reset_n), .ioReq(ioReq), .extCountPin(extPin),
		.capturePin(capPin), .comparatorOut(cmpOut), .captureFromComparator(capFromCmp),
		.ioRdData(rdData), .irqOverflow(irqOverflow), .irqCompareA(irqCompareA),
		.irqCompareB(irqCompareB), .irqCapture(irqCapture), .cmpOutA(cmpA), .cmpOutB(cmpB),
		.countFloor(countFloor), .countMax(countMax)
	);

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", nTests, errors);
		if (errors == 0 && nTests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		nTests++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic cycles(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cycles

	task automatic waitSig(input bit useMax, input logic want);
		logic seen;
		nTests++;
		for (int i = 0; i < 64; i++) begin
			@(posedge sys_clk);
			#1;
			seen = useMax ? countMax : countFloor;
			if (seen === want) return;
		end
		errors++;
		$display("CHECK FAILED at %0t: got %h expected %h", $time, seen, want);
		end_sim();
	endtask : waitSig

	task automatic pulseExt(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			extPin <= 1'b1;
			repeat (4) @(posedge sys_clk);
			extPin <= 1'b0;
			repeat (4) @(posedge sys_clk);
		end
	endtask : pulseExt

	initial begin
		#(25ns * 20000);
		errors++;
		$display("CHECK FAILED at %0t: got %h expected %h", $time, 1'b0, 1'b1);
		end_sim();
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		extPin = 1'b0;
		capPin = 1'b0;
		cmpOut = 1'b0;
		capFromCmp = 1'b0;
		errors = 0;
		nTests = 0;
		repeat (6) @(posedge sys_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			cpu.rd8(ZERO_REGS[i], b);
			chk({8'h00, b}, 16'h0000);
		end
		cpu.wr8(ADDR_CTRL_A, 8'h51);
		cpu.rd8(ADDR_CTRL_A, b);
		chk({8'h00, b}, 16'h0051);
		cpu.wr8(ADDR_CTRL_B, 8'h48);
		cpu.rd8(ADDR_CTRL_B, b);
		chk({8'h00, b}, 16'h0048);
		cpu.wr8(ADDR_CTRL_A, 8'h00);
		cpu.wr8(ADDR_CTRL_B, 8'h40);
		// Holder sharing: compare reads bypass it, capture high reads return it.
		cpu.wr16(ADDR_CNT_L, 16'h1234);
		cpu.rd16(ADDR_CNT_L, w);
		chk(w, 16'h1234);
		cpu.wr16(ADDR_CMPA_L, 16'h5678);
		cpu.rd8(ADDR_CNT_L, b);
		cpu.rd8(ADDR_CMPA_H, b);
		chk({8'h00, b}, 16'h0056);
		cpu.rd8(ADDR_CAP_H, b);
		chk({8'h00, b}, 16'h0012);
		cpu.wr8(ADDR_CNT_H, 8'h9a);
		cpu.wr8(ADDR_CNT_L, 8'hbc);
		cpu.wr8(ADDR_CMPB_L, 8'hde);
		cpu.rd16(ADDR_CMPB_L, w);
		chk(w, 16'h9ade);
		// Capture from the pin and from the comparator, with flag and mask.
		cpu.wr16(ADDR_CNT_L, 16'h0345);
		cpu.wr8(ADDR_MASK, 8'h08);
		cpu.wr8(ADDR_FLAGS, 8'hff);
		@(posedge sys_clk);
		capPin <= 1'b1;
		cycles(8);
		cpu.rd16(ADDR_CAP_L, w);
		chk(w, 16'h0345);
		cpu.rd8(ADDR_FLAGS, b);
		chk({8'h00, b}, 16'h0008);
		chk({15'h0, irqCapture}, 16'h0001);
		cpu.wr8(ADDR_FLAGS, 8'h08);
		cycles(2);
		chk({15'h0, irqCapture}, 16'h0000);
		cpu.wr16(ADDR_CNT_L, 16'h0456);
		@(posedge sys_clk);
		capFromCmp <= 1'b1;
		cycles(2);
		cmpOut <= 1'b1;
		cycles(4);
		cpu.rd16(ADDR_CAP_L, w);
		chk(w, 16'h0456);
		// Compare matches while counting at the full clock rate.
		cpu.wr16(ADDR_CMPA_L, 16'h0010);
		cpu.wr16(ADDR_CMPB_L, 16'h0018);
		cpu.wr16(ADDR_CNT_L, 16'h0008);
		cpu.wr8(ADDR_FLAGS, 8'hff);
		cpu.wr8(ADDR_CTRL_A, 8'h50);
		cpu.wr8(ADDR_CTRL_B, 8'h41);
		cycles(40);
		cpu.wr8(ADDR_CTRL_B, 8'h40);
		cpu.rd8(ADDR_FLAGS, b);
		chk({8'h00, b}, 16'h0060);
		chk({14'h0, cmpA, cmpB}, 16'h0003);
		cpu.wr8(ADDR_MASK, 8'h60);
		cycles(2);
		chk({14'h0, irqCompareA, irqCompareB}, 16'h0003);
		// Maximum, floor and overflow through the wrap.
		cpu.wr16(ADDR_CNT_L, 16'hfff0);
		cpu.wr8(ADDR_FLAGS, 8'hff);
		cpu.wr8(ADDR_CTRL_B, 8'h41);
		waitSig(1'b1, 1'b1);
		waitSig(1'b0, 1'b1);
		cpu.wr8(ADDR_CTRL_B, 8'h40);
		cpu.rd8(ADDR_FLAGS, b);
		chk({8'h00, b & 8'h80}, 16'h0080);
		chk({15'h0, irqOverflow}, 16'h0000);
		cpu.wr8(ADDR_MASK, 8'h88);
		cycles(2);
		chk({15'h0, irqOverflow}, 16'h0001);
		// Fixed top of 0x00ff in the 8-bit fast PWM mode wraps early.
		cpu.wr8(ADDR_CTRL_A, 8'h01);
		cpu.wr8(ADDR_CTRL_B, 8'h48);
		cpu.wr16(ADDR_CNT_L, 16'h00f0);
		cpu.wr8(ADDR_CTRL_B, 8'h49);
		waitSig(1'b0, 1'b1);
		cpu.wr8(ADDR_CTRL_B, 8'h40);
		cpu.wr8(ADDR_CTRL_A, 8'h00);
		// External count pin on each edge polarity, then stopped.
		for (int e = 0; e < 2; e++) begin
			cpu.wr16(ADDR_CNT_L, 16'h0000);
			cpu.wr8(ADDR_CTRL_B, (e == 0) ? {5'h08, CS_EXT_RISE} : {5'h08, CS_EXT_FALL});
			pulseExt(3);
			cycles(4);
			cpu.wr8(ADDR_CTRL_B, 8'h40);
			cycles(10);
			cpu.rd16(ADDR_CNT_L, w);
			chk(w, 16'h0003);
		end
		// Prescaler restart holds off the divide-by-8 tap.
		cpu.wr16(ADDR_CNT_L, 16'h0000);
		cpu.wr8(ADDR_GTC, 8'hff);
		cpu.wr8(ADDR_CTRL_B, 8'h42);
		cycles(3);
		chk({15'h0, countFloor}, 16'h0001);
		waitSig(1'b0, 1'b0);
		cpu.rd8(ADDR_GTC, b);
		chk({8'h00, b}, 16'h0000);
		end_sim();
	end

endmodule : test_wt_timer
